// ---- include/fhcs_pkg.sv ----
// Purpose: shared constants and types of the flash host command and status block
// Assumes: 16-bit host word bus, 256-block array of 64 pages of 1KB
// Notes:   offsets are word addresses as seen on the host address pins
package fhcs_pkg;

    // ----------
    // bus and array geometry
    // ----------
    localparam int unsigned ADDR_W       = 16;
    localparam int unsigned DATA_W       = 16;
    localparam int unsigned BLOCK_W      = 8;
    localparam int unsigned BLOCK_COUNT  = 256;
    localparam int unsigned PAGE_W       = 6;

    // ----------
    // boot partition address windows
    // ----------
    localparam logic [15:0] BOOT_LO_FIRST  = 16'h0000;
    localparam logic [15:0] BOOT_LO_LAST   = 16'h01FF;
    localparam logic [15:0] BOOT_HI_FIRST  = 16'h8000;
    localparam logic [15:0] BOOT_HI_LAST   = 16'h800F;

    // ----------
    // register offsets
    // ----------
    localparam logic [15:0] OFS_FLASH_BLOCK_START  = 16'hF100;
    localparam logic [15:0] OFS_FLASH_PAGE_START   = 16'hF107;
    localparam logic [15:0] OFS_PROTECT_RANGE_START = 16'hF24C;
    localparam logic [15:0] OFS_PROTECT_RANGE_END  = 16'hF24D;
    localparam logic [15:0] OFS_BLOCK_PROT_STATUS  = 16'hF24E;
    localparam logic [15:0] OFS_ECC_SUMMARY        = 16'hFF00;
    localparam logic [15:0] OFS_ECC_FIRST_MAIN     = 16'hFF01;
    localparam logic [15:0] OFS_ECC_FIRST_SPARE    = 16'hFF02;
    localparam logic [15:0] OFS_ECC_SECOND_MAIN    = 16'hFF03;
    localparam logic [15:0] OFS_ECC_SECOND_SPARE   = 16'hFF04;

    // ----------
    // identification read addresses
    // ----------
    localparam logic [15:0] ID_ADDR_MAKER   = 16'h0000;
    localparam logic [15:0] ID_ADDR_DEVICE  = 16'h0001;
    localparam logic [15:0] ID_ADDR_PROT    = 16'h0002;

    // ----------
    // command words
    // ----------
    localparam logic [15:0] CMD_RESET       = 16'h00F0;
    localparam logic [15:0] CMD_LOAD_FIRST  = 16'h00E0;
    localparam logic [15:0] CMD_LOAD_SECOND = 16'h0000;
    localparam logic [15:0] CMD_READ_ID     = 16'h0090;

    // ----------
    // reset values and field positions
    // ----------
    localparam logic [15:0] RST_PROT_STATUS  = 16'h0002;
    localparam logic [15:0] RST_ZERO         = 16'h0000;
    localparam int unsigned POS_UNLOCKED     = 2;
    localparam int unsigned POS_LOCKED       = 1;
    localparam int unsigned POS_LOCK_TIGHT   = 0;
    localparam int unsigned POS_WORD_LSB     = 4;
    localparam int unsigned POS_SPARE_SEL    = 4;
    localparam int unsigned POS_ECC_M1       = 6;
    localparam int unsigned POS_ECC_S1       = 4;
    localparam int unsigned POS_ECC_M0       = 2;
    localparam int unsigned POS_ECC_S0       = 0;

    // ----------
    // per-block protection state and protection commands
    // ----------
    typedef enum logic [1:0] {
        FHCS_PROT_UNLOCKED   = 2'h0,
        FHCS_PROT_LOCKED     = 2'h1,
        FHCS_PROT_LOCK_TIGHT = 2'h2
    } fhcs_prot_t;

    typedef enum logic [1:0] {
        FHCS_PCMD_NONE       = 2'h0,
        FHCS_PCMD_UNLOCK     = 2'h1,
        FHCS_PCMD_LOCK       = 2'h2,
        FHCS_PCMD_LOCK_TIGHT = 2'h3
    } fhcs_pcmd_t;

    // ----------
    // command sequencer states
    // ----------
    typedef enum logic [3:0] {
        FHCS_ST_READY   = 4'h1,
        FHCS_ST_ARMED   = 4'h2,
        FHCS_ST_LOADING = 4'h4,
        FHCS_ST_IDENT   = 4'h8
    } fhcs_state_t;

endpackage

// ---- src/fhcs_ecc_rec.sv ----
// Purpose: capture ECC results and error positions after each load
// Assumes: capture_i is a one-cycle pulse at the end of any load
// Notes:   outputs are the five ECC register images, reserved bits zero
`timescale 1ns/100ps
`default_nettype none

module fhcs_ecc_rec (
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    input  wire logic        clear_i,
    input  wire logic        capture_i,
    input  wire logic [1:0]  main0_res_i,
    input  wire logic [1:0]  spare0_res_i,
    input  wire logic [1:0]  main1_res_i,
    input  wire logic [1:0]  spare1_res_i,
    input  wire logic [7:0]  main0_word_i,
    input  wire logic [3:0]  main0_dq_i,
    input  wire logic [1:0]  spare0_sel_i,
    input  wire logic [3:0]  spare0_dq_i,
    input  wire logic [7:0]  main1_word_i,
    input  wire logic [3:0]  main1_dq_i,
    input  wire logic [1:0]  spare1_sel_i,
    input  wire logic [3:0]  spare1_dq_i,
    output logic      [15:0] summary_o,
    output logic      [15:0] first_main_o,
    output logic      [15:0] first_spare_o,
    output logic      [15:0] second_main_o,
    output logic      [15:0] second_spare_o
);

    typedef struct packed {
        logic [15:0] summary;
        logic [15:0] first_main;
        logic [15:0] first_spare;
        logic [15:0] second_main;
        logic [15:0] second_spare;
    } fhcs_ecc_state_t;

    fhcs_ecc_state_t r;
    fhcs_ecc_state_t next_r;

    // ----------
    // capture
    // ----------
    always_comb begin
        next_r = r;
        if (clear_i) begin
            next_r = '0;
        end else if (capture_i) begin
            next_r.summary = {8'h00, main1_res_i, spare1_res_i, main0_res_i, spare0_res_i};
            next_r.first_main   = {4'h0, main0_word_i, main0_dq_i};
            next_r.first_spare  = {10'h000, spare0_sel_i, spare0_dq_i};
            next_r.second_main  = {4'h0, main1_word_i, main1_dq_i};
            next_r.second_spare = {10'h000, spare1_sel_i, spare1_dq_i};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign summary_o      = r.summary;
    assign first_main_o   = r.first_main;
    assign first_spare_o  = r.first_spare;
    assign second_main_o  = r.second_main;
    assign second_spare_o = r.second_spare;

endmodule

`default_nettype wire

// ---- src/fhcs_core.sv ----
// Purpose: host command interpreter, protection and ECC status registers
// Assumes: host bus strobes are one-cycle pulses synchronous to ref_clk_i
// Notes:   read data returns one cycle after the read strobe
`timescale 1ns/100ps
`default_nettype none

// How it works
// - range end register bounds protection commands
// - status shows unlocked, locked, lock-tight flags
// - status resets to locked, writes ignored
// - two-bit ECC code per sector each load
// - ECC summary holds four two-bit results
// - three-bit or larger errors may misreport
// - record main word index and dq index
// - spare word selector in bits five four
// - boot load updates ECC fields too
// - commands decoded only in boot partition
// - boot reads give boot data until command issued
// - writes outside boot partition never commands
// - execute only after all cycles received
// - bad cycle abandons sequence, back to ready
// - F0 write restores all defaults
// - E0 then 0000 loads one page
// - page increments after load, wraps in block
// - block and page start default zero
// - after 90, read gives identification data
// - write strobe ends identification mode
// - load end raises load done flag
// - range start register bounds protection commands
module fhcs_core #(
    parameter logic [15:0] MAKER_CODE  = 16'h0A5A, // arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'h0123  // arbitrary value
) (
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    input  wire logic [15:0] bus_addr_i,
    input  wire logic [15:0] bus_wdata_i,
    input  wire logic        bus_we_i,
    input  wire logic        bus_re_i,
    input  wire logic [15:0] boot_rdata_i,
    input  wire logic [15:0] buf_rdata_i,
    input  wire logic [1:0]  prot_cmd_i,
    input  wire logic        load_done_i,
    input  wire logic        boot_load_done_i,
    input  wire logic [1:0]  main0_res_i,
    input  wire logic [1:0]  spare0_res_i,
    input  wire logic [1:0]  main1_res_i,
    input  wire logic [1:0]  spare1_res_i,
    input  wire logic [7:0]  main0_word_i,
    input  wire logic [3:0]  main0_dq_i,
    input  wire logic [1:0]  spare0_sel_i,
    input  wire logic [3:0]  spare0_dq_i,
    input  wire logic [7:0]  main1_word_i,
    input  wire logic [3:0]  main1_dq_i,
    input  wire logic [1:0]  spare1_sel_i,
    input  wire logic [3:0]  spare1_dq_i,
    output logic      [15:0] bus_rdata_o,
    output logic             bus_rvalid_o,
    output logic             load_req_o,
    output logic      [7:0]  load_block_o,
    output logic      [5:0]  load_page_o,
    output logic             load_done_flag_o,
    output logic             busy_o
);

    // ----------
    // state
    // ----------
    typedef struct packed {
        fhcs_pkg::fhcs_state_t                 state;
        logic                                  cmd_issued;
        logic [fhcs_pkg::BLOCK_W-1:0]          block_start;
        logic [fhcs_pkg::PAGE_W-1:0]           page_start;
        logic [fhcs_pkg::BLOCK_W-1:0]          range_start;
        logic [fhcs_pkg::BLOCK_W-1:0]          range_end;
        logic [fhcs_pkg::BLOCK_COUNT-1:0][1:0] prot;
        logic [15:0]                           rdata;
        logic                                  rvalid;
        logic                                  load_req;
        logic                                  load_done;
    } fhcs_core_state_t;

    fhcs_core_state_t r;
    fhcs_core_state_t next_r;

    logic [15:0] ecc_summary;
    logic [15:0] ecc_first_main;
    logic [15:0] ecc_first_spare;
    logic [15:0] ecc_second_main;
    logic [15:0] ecc_second_spare;
    logic        soft_reset;
    logic        ecc_capture;
    logic [15:0] prot_status;

    // ----------
    // decoding helpers
    // ----------
    function automatic logic in_boot(input logic [15:0] a);
        in_boot = ((a >= fhcs_pkg::BOOT_LO_FIRST) && (a <= fhcs_pkg::BOOT_LO_LAST)) ||
                  ((a >= fhcs_pkg::BOOT_HI_FIRST) && (a <= fhcs_pkg::BOOT_HI_LAST));
    endfunction

    function automatic logic [15:0] status_of(input logic [1:0] s);
        status_of = '0;
        status_of[fhcs_pkg::POS_UNLOCKED]   = (s == fhcs_pkg::FHCS_PROT_UNLOCKED);
        status_of[fhcs_pkg::POS_LOCKED]     = (s == fhcs_pkg::FHCS_PROT_LOCKED);
        status_of[fhcs_pkg::POS_LOCK_TIGHT] = (s == fhcs_pkg::FHCS_PROT_LOCK_TIGHT);
    endfunction

    // ----------
    // ECC result recorder
    // ----------
    // host and boot loads capture alike; three-bit errors are shown as reported
    assign ecc_capture = load_done_i || boot_load_done_i;

    fhcs_ecc_rec u_ecc (
        .ref_clk_i      (ref_clk_i),
        .reset_i        (reset_i),
        .clear_i        (soft_reset),
        .capture_i      (ecc_capture),
        .main0_res_i    (main0_res_i),
        .spare0_res_i   (spare0_res_i),
        .main1_res_i    (main1_res_i),
        .spare1_res_i   (spare1_res_i),
        .main0_word_i   (main0_word_i),
        .main0_dq_i     (main0_dq_i),
        .spare0_sel_i   (spare0_sel_i),
        .spare0_dq_i    (spare0_dq_i),
        .main1_word_i   (main1_word_i),
        .main1_dq_i     (main1_dq_i),
        .spare1_sel_i   (spare1_sel_i),
        .spare1_dq_i    (spare1_dq_i),
        .summary_o      (ecc_summary),
        .first_main_o   (ecc_first_main),
        .first_spare_o  (ecc_first_spare),
        .second_main_o  (ecc_second_main),
        .second_spare_o (ecc_second_spare)
    );

    // ----------
    // current block status
    // ----------
    assign prot_status = status_of(r.prot[r.block_start]);

    assign soft_reset = bus_we_i && in_boot(bus_addr_i) && (bus_wdata_i == fhcs_pkg::CMD_RESET);

    // ----------
    // default values
    // ----------
    function automatic fhcs_core_state_t defaults();
        fhcs_core_state_t d;
        d             = '0;
        d.state       = fhcs_pkg::FHCS_ST_READY;
        d.block_start = '0;
        d.page_start  = '0;
        for (int i = 0; i < fhcs_pkg::BLOCK_COUNT; i++) begin
            d.prot[i] = fhcs_pkg::FHCS_PROT_LOCKED;
        end
        defaults = d;
    endfunction

    // ----------
    // next state
    // ----------
    always_comb begin
        logic        boot_wr;
        logic        reg_wr;
        logic        in_range;
        logic [15:0] rd;
        boot_wr  = bus_we_i && in_boot(bus_addr_i);
        reg_wr   = bus_we_i && !in_boot(bus_addr_i);
        in_range = 1'b0;
        rd       = '0;
        next_r   = r;
        next_r.load_req  = 1'b0;
        next_r.load_done = 1'b0;
        next_r.rvalid    = 1'b0;

        // protection range commands
        for (int i = 0; i < fhcs_pkg::BLOCK_COUNT; i++) begin
            in_range = (i[7:0] >= r.range_start) && (i[7:0] <= r.range_end);
            if (in_range && r.prot[i] != fhcs_pkg::FHCS_PROT_LOCK_TIGHT) begin
                case (prot_cmd_i)
                    fhcs_pkg::FHCS_PCMD_UNLOCK: begin
                        next_r.prot[i] = fhcs_pkg::FHCS_PROT_UNLOCKED;
                    end
                    fhcs_pkg::FHCS_PCMD_LOCK: begin
                        next_r.prot[i] = fhcs_pkg::FHCS_PROT_LOCKED;
                    end
                    fhcs_pkg::FHCS_PCMD_LOCK_TIGHT: begin
                        if (r.prot[i] == fhcs_pkg::FHCS_PROT_LOCKED) begin
                            next_r.prot[i] = fhcs_pkg::FHCS_PROT_LOCK_TIGHT;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // register writes outside the boot partition
        if (reg_wr) begin
            if (bus_addr_i == fhcs_pkg::OFS_FLASH_BLOCK_START) begin
                next_r.block_start = bus_wdata_i[fhcs_pkg::BLOCK_W-1:0];
            end else if (bus_addr_i == fhcs_pkg::OFS_FLASH_PAGE_START) begin
                next_r.page_start = bus_wdata_i[fhcs_pkg::PAGE_W-1:0];
            end else if (bus_addr_i == fhcs_pkg::OFS_PROTECT_RANGE_START) begin
                next_r.range_start = bus_wdata_i[fhcs_pkg::BLOCK_W-1:0];
            end else if (bus_addr_i == fhcs_pkg::OFS_PROTECT_RANGE_END) begin
                next_r.range_end = bus_wdata_i[fhcs_pkg::BLOCK_W-1:0];
            end
        end

        // command sequencer
        case (r.state)
            fhcs_pkg::FHCS_ST_READY: begin
                if (boot_wr && bus_wdata_i == fhcs_pkg::CMD_LOAD_FIRST) begin
                    next_r.state      = fhcs_pkg::FHCS_ST_ARMED;
                    next_r.cmd_issued = 1'b1;
                end else if (boot_wr && bus_wdata_i == fhcs_pkg::CMD_READ_ID) begin
                    next_r.state      = fhcs_pkg::FHCS_ST_IDENT;
                    next_r.cmd_issued = 1'b1;
                end
            end
            fhcs_pkg::FHCS_ST_ARMED: begin
                if (boot_wr && bus_wdata_i == fhcs_pkg::CMD_LOAD_SECOND) begin
                    next_r.state      = fhcs_pkg::FHCS_ST_LOADING;
                    next_r.load_req   = 1'b1;
                end else if (bus_we_i) begin
                    next_r.state      = fhcs_pkg::FHCS_ST_READY;
                end
            end
            fhcs_pkg::FHCS_ST_LOADING: begin
                if (load_done_i) begin
                    next_r.state      = fhcs_pkg::FHCS_ST_READY;
                    next_r.page_start = r.page_start + 6'h01;
                end
            end
            fhcs_pkg::FHCS_ST_IDENT: begin
                if (bus_we_i) begin
                    next_r.state = fhcs_pkg::FHCS_ST_READY;
                end
            end
            default: begin
                next_r.state = fhcs_pkg::FHCS_ST_READY;
            end
        endcase

        if (ecc_capture) begin
            next_r.load_done = 1'b1;
        end

        // read path
        if (bus_re_i) begin
            next_r.rvalid = 1'b1;
            if (in_boot(bus_addr_i)) begin
                if (r.state == fhcs_pkg::FHCS_ST_IDENT) begin
                    if (bus_addr_i == fhcs_pkg::ID_ADDR_MAKER) begin
                        rd = MAKER_CODE;
                    end else if (bus_addr_i == fhcs_pkg::ID_ADDR_DEVICE) begin
                        rd = DEVICE_CODE;
                    end else if (bus_addr_i == fhcs_pkg::ID_ADDR_PROT) begin
                        rd = prot_status;
                    end
                end else if (!r.cmd_issued) begin
                    rd = boot_rdata_i;
                end
            end else if (bus_addr_i == fhcs_pkg::OFS_FLASH_BLOCK_START) begin
                rd = {8'h00, r.block_start};
            end else if (bus_addr_i == fhcs_pkg::OFS_FLASH_PAGE_START) begin
                rd = {10'h000, r.page_start};
            end else if (bus_addr_i == fhcs_pkg::OFS_PROTECT_RANGE_START) begin
                rd = {8'h00, r.range_start};
            end else if (bus_addr_i == fhcs_pkg::OFS_PROTECT_RANGE_END) begin
                rd = {8'h00, r.range_end};
            end else if (bus_addr_i == fhcs_pkg::OFS_BLOCK_PROT_STATUS) begin
                rd = prot_status;
            end else if (bus_addr_i == fhcs_pkg::OFS_ECC_SUMMARY) begin
                rd = ecc_summary;
            end else if (bus_addr_i == fhcs_pkg::OFS_ECC_FIRST_MAIN) begin
                rd = ecc_first_main;
            end else if (bus_addr_i == fhcs_pkg::OFS_ECC_FIRST_SPARE) begin
                rd = ecc_first_spare;
            end else if (bus_addr_i == fhcs_pkg::OFS_ECC_SECOND_MAIN) begin
                rd = ecc_second_main;
            end else if (bus_addr_i == fhcs_pkg::OFS_ECC_SECOND_SPARE) begin
                rd = ecc_second_spare;
            end else begin
                rd = buf_rdata_i;
            end
            next_r.rdata = rd;
        end

        // reset command wins over everything above but the same-cycle read answer
        if (soft_reset) begin
            next_r           = defaults();
            next_r.rvalid    = bus_re_i;
            next_r.rdata     = rd;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            r <= defaults();
        end else begin
            r <= next_r;
        end
    end

    // ----------
    // outputs
    // ----------
    assign bus_rdata_o      = r.rdata;
    assign bus_rvalid_o     = r.rvalid;
    assign load_req_o       = r.load_req;
    assign load_block_o     = r.block_start;
    assign load_page_o      = r.page_start;
    assign load_done_flag_o = r.load_done;
    // one-hot loading bit, straight from its flop
    assign busy_o           = r.state[2];

endmodule

`default_nettype wire

// ---- verification/fhcs_checker.sv ----
// Purpose: port-level timing checks of fhcs_core
// Assumes: single clock, synchronous active-high reset
// Notes:   bound to every fhcs_core instance
`timescale 1ns/100ps
`default_nettype none
module fhcs_checker (
    input wire logic        ref_clk_i,
    input wire logic        reset_i,
    input wire logic [15:0] bus_addr_i,
    input wire logic [15:0] bus_wdata_i,
    input wire logic        bus_we_i,
    input wire logic        bus_re_i,
    input wire logic        load_done_i,
    input wire logic        boot_load_done_i,
    input wire logic [15:0] bus_rdata_o,
    input wire logic        bus_rvalid_o,
    input wire logic        load_req_o,
    input wire logic [5:0]  load_page_o,
    input wire logic        load_done_flag_o,
    input wire logic        busy_o
);
    wire logic in_boot = bus_addr_i <= 16'h01FF || (bus_addr_i >= 16'h8000 && bus_addr_i <= 16'h800F);
    wire logic soft_rst = bus_we_i && in_boot && bus_wdata_i == 16'h00F0;
    wire logic any_done = load_done_i || boot_load_done_i;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    a_read_answer: assert property (bus_rvalid_o == $past(bus_re_i))
        else $error("read answer timing wrong");
    a_req_last_cycle: assert property (load_req_o |-> $past(bus_we_i && in_boot && bus_wdata_i == 16'h0000))
        else $error("load request without second cycle");
    a_no_cmd_outside: assert property (bus_we_i && !in_boot |=> !load_req_o)
        else $error("command taken outside boot area");
    a_busy_on_req: assert property (load_req_o |-> busy_o)
        else $error("busy low during load request");
    a_busy_release: assert property (load_done_i && busy_o |=> !busy_o)
        else $error("busy held after load done");
    a_flag_on_done: assert property (any_done && !soft_rst |=> load_done_flag_o)
        else $error("load done flag missing");
    a_flag_cause: assert property (load_done_flag_o |-> $past(any_done))
        else $error("load done flag without load end");
    a_page_step: assert property (load_done_i && busy_o && !bus_we_i |=> load_page_o == $past(load_page_o) + 6'h01)
        else $error("page did not advance by one");
    a_status_shape: assert property (bus_re_i && bus_addr_i == 16'hF24E |=> bus_rdata_o[15:3] == 13'h0000 && $onehot(bus_rdata_o[2:0]))
        else $error("protection status malformed");
    a_ecc_reserved: assert property (bus_re_i && bus_addr_i == 16'hFF00 |=> bus_rdata_o[15:8] == 8'h00)
        else $error("ecc summary reserved bits set");
endmodule
bind fhcs_core fhcs_checker u_fhcs_checker (.ref_clk_i, .reset_i, .bus_addr_i, .bus_wdata_i, .bus_we_i, .bus_re_i,
    .load_done_i, .boot_load_done_i, .bus_rdata_o, .bus_rvalid_o, .load_req_o, .load_page_o, .load_done_flag_o, .busy_o);
`default_nettype wire

// ---- verification/fhcs_nand_model.sv ----
// Purpose: flash core model answering page load requests
// Assumes: one request outstanding at a time
// Notes:   ecc fields are garbage outside the done cycle
`timescale 1ns/100ps
`default_nettype none
module fhcs_nand_model (
    input  wire logic        ref_clk_i,
    input  wire logic        load_req_i,
    input  wire logic        boot_done_i,
    output logic             load_done_o,
    output logic      [43:0] ecc_o
);
    localparam logic [43:0] ECC_VAL = {2'h1, 2'h2, 2'h0, 2'h1, 8'hA5, 4'h3, 2'h1, 4'h7, 8'h3C, 4'hC, 2'h0, 4'h9};
    logic slow = 1'b0;
    initial load_done_o = 1'b0;
    // one page per request, alternately prompt and slow
    always @(posedge ref_clk_i) begin
        if (load_req_i) begin
            slow <= ~slow;
            repeat (slow ? 6 : 1) @(posedge ref_clk_i);
            load_done_o <= 1'b1;
            @(posedge ref_clk_i);
            load_done_o <= 1'b0;
        end
    end
    // legal codes and positions only in the done cycle
    assign ecc_o = (load_done_o || boot_done_i) ? ECC_VAL : ~ECC_VAL;
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// Purpose: register and command tests of fhcs_core
// Assumes: default maker 0A5A and device 0123 codes
// Notes:   inputs change on rising edges by non-blocking assignment
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        ref_clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [15:0] bus_addr_i = 16'h0000;
    logic [15:0] bus_wdata_i = 16'h0000;
    logic        bus_we_i = 1'b0;
    logic        bus_re_i = 1'b0;
    logic [15:0] boot_rdata_i = 16'h1234;
    logic [15:0] buf_rdata_i = 16'hBEEF;
    logic [1:0]  prot_cmd_i = 2'h0;
    logic        boot_load_done_i = 1'b0;
    logic        load_done_i, bus_rvalid_o, load_req_o, load_done_flag_o, busy_o;
    logic [43:0] ecc;
    logic [15:0] bus_rdata_o;
    logic [7:0]  load_block_o;
    logic [5:0]  load_page_o;
    logic [15:0] ecc_exp [5] = '{16'h0016, 16'h0A53, 16'h0017, 16'h03CC, 16'h0009};
    int          n_fail = 0;
    int          comparisons = 0;
    always #2 ref_clk_i = ~ref_clk_i;
    fhcs_core u_fhcs_core (.ref_clk_i, .reset_i, .bus_addr_i, .bus_wdata_i, .bus_we_i, .bus_re_i, .boot_rdata_i,
        .buf_rdata_i, .prot_cmd_i, .load_done_i, .boot_load_done_i, .main0_res_i(ecc[43:42]), .spare0_res_i(ecc[41:40]),
        .main1_res_i(ecc[39:38]), .spare1_res_i(ecc[37:36]), .main0_word_i(ecc[35:28]), .main0_dq_i(ecc[27:24]),
        .spare0_sel_i(ecc[23:22]), .spare0_dq_i(ecc[21:18]), .main1_word_i(ecc[17:10]), .main1_dq_i(ecc[9:6]),
        .spare1_sel_i(ecc[5:4]), .spare1_dq_i(ecc[3:0]), .bus_rdata_o, .bus_rvalid_o, .load_req_o, .load_block_o,
        .load_page_o, .load_done_flag_o, .busy_o);
    fhcs_nand_model u_fhcs_nand_model (.ref_clk_i, .load_req_i(load_req_o), .boot_done_i(boot_load_done_i),
        .load_done_o(load_done_i), .ecc_o(ecc));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        bus_we_i <= 1'b1;
        bus_addr_i <= a;
        bus_wdata_i <= d;
        @(posedge ref_clk_i);
        bus_we_i <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge ref_clk_i);
        bus_re_i <= 1'b1;
        bus_addr_i <= a;
        @(posedge ref_clk_i);
        bus_re_i <= 1'b0;
        @(negedge ref_clk_i);
        chk({15'h0000, bus_rvalid_o}, 16'h0001);
        chk(bus_rdata_o, e);
    endtask
    task automatic ecc_chk(input bit loaded);
        for (int k = 0; k < 5; k++)
            rd(16'hFF00 + 16'(k), loaded ? ecc_exp[k] : 16'h0000);
    endtask
    task automatic load(input logic [15:0] a);
        wr(a, 16'h00E0);
        wr(a, 16'h0000);
        for (int i = 0; i < 40 && load_done_flag_o !== 1'b1; i++)
            @(negedge ref_clk_i);
        chk({15'h0000, load_done_flag_o}, 16'h0001);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #20000;
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        stop_test();
    end
    initial begin
        repeat (12) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        rd(16'h0010, 16'h1234);
        rd(16'hF300, 16'hBEEF);
        rd(16'hF24D, 16'h0000);
        rd(16'hF24E, 16'h0002);
        ecc_chk(1'b0);
        chk({load_block_o, 2'h0, load_page_o}, 16'h0000);
        wr(16'hF24E, 16'hFFFF);
        rd(16'hF24E, 16'h0002);
        wr(16'hF24D, 16'hFFFF);
        rd(16'hF24D, 16'h00FF);
        $display("reset and access test done");
        wr(16'h0000, 16'h0090);
        rd(16'h0000, 16'h0A5A);
        rd(16'h0001, 16'h0123);
        rd(16'h0002, 16'h0002);
        wr(16'hF24D, 16'h0000);
        rd(16'h0001, 16'h0000);
        $display("identification test done");
        wr(16'h0200, 16'h00E0);
        wr(16'h0000, 16'h0000);
        wr(16'h800F, 16'h00E0);
        wr(16'h800F, 16'h0012);
        wr(16'h800F, 16'h0000);
        repeat (10) @(posedge ref_clk_i);
        chk({10'h000, load_page_o}, 16'h0000);
        $display("abort test done");
        load(16'h800F);
        chk({10'h000, load_page_o}, 16'h0001);
        ecc_chk(1'b1);
        load(16'h0000);
        chk({10'h000, load_page_o}, 16'h0002);
        wr(16'hF100, 16'h0007);
        wr(16'hF107, 16'h003F);
        load(16'h01FF);
        chk({load_block_o, 2'h0, load_page_o}, 16'h0700);
        $display("load test done");
        wr(16'hF24C, 16'h0007);
        wr(16'hF24D, 16'h0007);
        for (int c = 1; c < 4; c++) begin
            @(posedge ref_clk_i);
            prot_cmd_i <= 2'(c);
            @(posedge ref_clk_i);
            prot_cmd_i <= 2'h0;
            rd(16'hF24E, 16'h0008 >> c);
        end
        wr(16'hF100, 16'h0008);
        rd(16'hF24E, 16'h0002);
        $display("protection test done");
        wr(16'h0100, 16'h00F0);
        rd(16'hF24D, 16'h0000);
        ecc_chk(1'b0);
        chk({load_block_o, 2'h0, load_page_o}, 16'h0000);
        rd(16'h0010, 16'h1234);
        @(posedge ref_clk_i);
        boot_load_done_i <= 1'b1;
        @(posedge ref_clk_i);
        boot_load_done_i <= 1'b0;
        @(negedge ref_clk_i);
        chk({15'h0000, load_done_flag_o}, 16'h0001);
        ecc_chk(1'b1);
        $display("soft reset and boot load test done");
        stop_test();
    end
endmodule
`default_nettype wire
